// ### design/cfe_cond_eval.sv
`timescale 1ns/1ps
module cfe_cond_eval
   import cfe_pkg::*;
(
   cfe_cond_if.eval br
);
   always_comb begin
      br.taken = cfe_test(br.code, br.flags);
      if (!br.taken) begin
         br.pc_dest = br.pc_next;
      end else if (br.rel) begin
         br.pc_dest = br.pc_next + {{8{br.offset[7]}}, br.offset};
      end else begin
         br.pc_dest = br.target;
      end
   end
endmodule

// ### design/cfe_top.sv
// Functional notes
// - Flags register at FCh short, 0FCh linear.
// - Carry flags carry/borrow out of bit 7.
// - Carry shifts through rotates and shifts.
// - Zero flag set when result is zero.
// - Decimal flag records add/subtract for adjust.
// - Half carry flags carry/borrow at bit 3.
// - User bits change only on explicit write.
// - Code 0 never true, code 8 always.
// - Four-bit test field selects one test.
// - Codes 4,5,6 test V, S, Z set.
// - Codes C,D,E test V, S, Z clear.
// - Codes 1,2: signed below, at most.
// - Codes 9,A: signed at least, above.
// - Codes 3,B: unsigned at most, above.
// - Codes 7,F: carry set, carry clear.
// - Branch taken only when test true.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module cfe_top
   import cfe_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // AXI4-Lite slave
   input wire logic s_axil_awvalid_i,
   output logic s_axil_awready_o,
   input wire logic [cfe_pkg::CFE_ADDR_W-1:0] s_axil_awaddr_i,
   input wire logic s_axil_wvalid_i,
   output logic s_axil_wready_o,
   input wire logic [31:0] s_axil_wdata_i,
   input wire logic [3:0] s_axil_wstrb_i,
   output logic s_axil_bvalid_o,
   input wire logic s_axil_bready_i,
   output logic [1:0] s_axil_bresp_o,
   input wire logic s_axil_arvalid_i,
   output logic s_axil_arready_o,
   input wire logic [cfe_pkg::CFE_ADDR_W-1:0] s_axil_araddr_i,
   output logic s_axil_rvalid_o,
   input wire logic s_axil_rready_i,
   output logic [31:0] s_axil_rdata_o,
   output logic [1:0] s_axil_rresp_o,
   // Datapath operation
   input wire logic alu_valid_i,
   input wire cfe_pkg::cfe_op_type alu_op_i,
   input wire logic [7:0] alu_a_i,
   input wire logic [7:0] alu_b_i,
   output logic [7:0] alu_result_o,
   output logic alu_result_valid_o,
   // Core register write port
   input wire logic core_wr_i,
   input wire logic core_short_i,
   input wire logic [cfe_pkg::CFE_ADDR_W-1:0] core_addr_i,
   input wire logic [7:0] core_wdata_i,
   output logic [7:0] flags_o,
   // Conditional branch
   input wire logic br_req_i,
   input wire logic br_rel_i,
   input wire logic [3:0] branch_test_field_i,
   input wire logic [15:0] br_target_i,
   input wire logic [7:0] br_offset_i,
   input wire logic [15:0] br_pc_next_i,
   output logic br_done_o,
   output logic br_taken_o,
   output logic [15:0] br_pc_o
);
   import cfe_pkg::*;

   logic [7:0] flags_ff;
   logic [7:0] nxt_flags;
   logic [7:0] alu_flags;
   logic [7:0] alu_res;
   logic alu_wr_res;
   logic [7:0] result_ff;
   logic result_valid_ff;
   logic awready_ff;
   logic wready_ff;
   logic aw_got_ff;
   logic w_got_ff;
   logic [11:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic arready_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic wr_fire;
   logic wr_known;
   logic axi_flag_wr;
   logic core_flag_wr;
   logic [31:0] rd_word;
   logic rd_known;
   logic br_done_ff;
   logic br_taken_ff;
   logic [15:0] br_pc_ff;
   logic [4:0] brstat_ff;

   // ----------------------------------------------------------------
   // Arithmetic and flag computation
   // ----------------------------------------------------------------
   always_comb begin
      logic [8:0] sum;
      logic [4:0] low;
      logic cin;
      logic c;
      logic [7:0] adj;
      sum = 9'h000;
      low = 5'h00;
      adj = 8'h00;
      c = flags_ff[CFE_C_BIT];
      cin = ((alu_op_i == CFE_OP_ADC) || (alu_op_i == CFE_OP_SBC)) ? c : 1'b0;
      alu_res = alu_a_i;
      alu_wr_res = 1'b1;
      alu_flags = flags_ff;
      case (alu_op_i)
         CFE_OP_ADD, CFE_OP_ADC: begin
            sum = {1'b0, alu_a_i} + {1'b0, alu_b_i} + {8'h00, cin};
            low = {1'b0, alu_a_i[3:0]} + {1'b0, alu_b_i[3:0]} + {4'h0, cin};
            alu_res = sum[7:0];
            alu_flags[CFE_C_BIT] = sum[8];
            alu_flags[CFE_H_BIT] = low[4];
            alu_flags[CFE_D_BIT] = 1'b0;
            alu_flags[CFE_V_BIT] = (alu_a_i[7] == alu_b_i[7]) && (sum[7] != alu_a_i[7]);
         end
         CFE_OP_SUB, CFE_OP_SBC, CFE_OP_CP: begin
            sum = {1'b0, alu_a_i} - {1'b0, alu_b_i} - {8'h00, cin};
            low = {1'b0, alu_a_i[3:0]} - {1'b0, alu_b_i[3:0]} - {4'h0, cin};
            alu_res = sum[7:0];
            alu_wr_res = (alu_op_i != CFE_OP_CP);
            alu_flags[CFE_C_BIT] = sum[8];
            alu_flags[CFE_H_BIT] = low[4];
            alu_flags[CFE_D_BIT] = 1'b1;
            alu_flags[CFE_V_BIT] = (alu_a_i[7] != alu_b_i[7]) && (sum[7] != alu_a_i[7]);
         end
         CFE_OP_AND, CFE_OP_OR, CFE_OP_XOR, CFE_OP_COM: begin
            case (alu_op_i)
               CFE_OP_AND: alu_res = alu_a_i & alu_b_i;
               CFE_OP_OR: alu_res = alu_a_i | alu_b_i;
               CFE_OP_XOR: alu_res = alu_a_i ^ alu_b_i;
               default: alu_res = ~alu_a_i;
            endcase
            alu_flags[CFE_V_BIT] = 1'b0;
         end
         CFE_OP_INC, CFE_OP_DEC: begin
            // Counters leave carry alone so loops can test it
            alu_res = (alu_op_i == CFE_OP_INC) ? alu_a_i + 8'h01 : alu_a_i - 8'h01;
            alu_flags[CFE_V_BIT] = (alu_op_i == CFE_OP_INC) ? (alu_res == 8'h80) : (alu_res == 8'h7F);
         end
         CFE_OP_RL, CFE_OP_RLC: begin
            alu_res = {alu_a_i[6:0], (alu_op_i == CFE_OP_RL) ? alu_a_i[7] : c};
            alu_flags[CFE_C_BIT] = alu_a_i[7];
            alu_flags[CFE_V_BIT] = alu_res[7] ^ alu_a_i[7];
         end
         CFE_OP_RR, CFE_OP_RRC, CFE_OP_SRA, CFE_OP_SRL: begin
            case (alu_op_i)
               CFE_OP_RR: alu_res = {alu_a_i[0], alu_a_i[7:1]};
               CFE_OP_RRC: alu_res = {c, alu_a_i[7:1]};
               CFE_OP_SRA: alu_res = {alu_a_i[7], alu_a_i[7:1]};
               default: alu_res = {1'b0, alu_a_i[7:1]};
            endcase
            alu_flags[CFE_C_BIT] = alu_a_i[0];
            alu_flags[CFE_V_BIT] = alu_res[7] ^ alu_a_i[7];
         end
         CFE_OP_DA: begin
            // Uses D and H left by the previous add or subtract
            if (flags_ff[CFE_H_BIT] || (alu_a_i[3:0] > CFE_DA_NIB)) begin
               adj = CFE_DA_LO;
            end
            if (c || (alu_a_i > CFE_DA_MAX)) begin
               adj = adj | CFE_DA_HI;
            end
            alu_res = flags_ff[CFE_D_BIT] ? alu_a_i - adj : alu_a_i + adj;
            alu_flags[CFE_C_BIT] = c | adj[6];
         end
         CFE_OP_CCF, CFE_OP_RCF, CFE_OP_SCF: begin
            alu_wr_res = 1'b0;
            case (alu_op_i)
               CFE_OP_CCF: alu_flags[CFE_C_BIT] = ~c;
               CFE_OP_RCF: alu_flags[CFE_C_BIT] = 1'b0;
               default: alu_flags[CFE_C_BIT] = 1'b1;
            endcase
         end
         default: alu_wr_res = 1'b0;
      endcase
      if (alu_op_i != CFE_OP_CCF && alu_op_i != CFE_OP_RCF && alu_op_i != CFE_OP_SCF) begin
         alu_flags[CFE_Z_BIT] = (alu_res == 8'h00);
         alu_flags[CFE_S_BIT] = alu_res[7];
      end
      alu_flags[CFE_U1_BIT] = flags_ff[CFE_U1_BIT];
      alu_flags[CFE_U2_BIT] = flags_ff[CFE_U2_BIT];
   end

   // ----------------------------------------------------------------
   // Flags register
   // ----------------------------------------------------------------
   assign core_flag_wr = core_wr_i && cfe_hits_flags(core_addr_i, core_short_i);
   assign axi_flag_wr = wr_fire && wstrb_ff[0] && cfe_hits_flags(awaddr_ff, 1'b0);

   always_comb begin
      nxt_flags = flags_ff;
      if (alu_valid_i) begin
         nxt_flags = alu_flags;
      end
      if (axi_flag_wr) begin
         nxt_flags = wdata_ff[7:0];
      end
      if (core_flag_wr) begin
         nxt_flags = core_wdata_i;
      end
   end

   // Reset value is a convenience only; software may not rely on it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_ff <= CFE_FLAGS_RST;
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result_ff <= 8'h00;
         result_valid_ff <= 1'b0;
      end else begin
         result_valid_ff <= alu_valid_i && alu_wr_res;
         if (alu_valid_i && alu_wr_res) begin
            result_ff <= alu_res;
         end
      end
   end

   // ----------------------------------------------------------------
   // Conditional branch
   // ----------------------------------------------------------------
   cfe_cond_if cond_bus ();

   assign cond_bus.flags = flags_ff;
   assign cond_bus.code = branch_test_field_i;
   assign cond_bus.rel = br_rel_i;
   assign cond_bus.target = br_target_i;
   assign cond_bus.offset = br_offset_i;
   assign cond_bus.pc_next = br_pc_next_i;

   cfe_cond_eval u_eval (
      .br(cond_bus.eval)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         br_done_ff <= 1'b0;
         br_taken_ff <= 1'b0;
         br_pc_ff <= 16'h0000;
         brstat_ff <= 5'h00;
      end else begin
         br_done_ff <= br_req_i;
         if (br_req_i) begin
            br_taken_ff <= cond_bus.taken;
            br_pc_ff <= cond_bus.pc_dest;
            brstat_ff <= {cond_bus.taken, branch_test_field_i};
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
   assign wr_known = (awaddr_ff == CFE_FLAGS_LIN_ADDR) || (awaddr_ff == CFE_BRSTAT_ADDR) ||
                     (awaddr_ff == CFE_RESULT_ADDR);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         awaddr_ff <= 12'h000;
         wdata_ff <= 32'h00000000;
         wstrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= CFE_RESP_OKAY;
      end else begin
         if (s_axil_awvalid_i && awready_ff) begin
            awready_ff <= 1'b0;
            aw_got_ff <= 1'b1;
            awaddr_ff <= s_axil_awaddr_i;
         end
         if (s_axil_wvalid_i && wready_ff) begin
            wready_ff <= 1'b0;
            w_got_ff <= 1'b1;
            wdata_ff <= s_axil_wdata_i;
            wstrb_ff <= s_axil_wstrb_i;
         end
         if (wr_fire) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_known ? CFE_RESP_OKAY : CFE_RESP_DECERR;
         end else if (bvalid_ff && s_axil_bready_i) begin
            bvalid_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   always_comb begin
      rd_word = 32'h00000000;
      rd_known = 1'b1;
      case (s_axil_araddr_i)
         CFE_FLAGS_LIN_ADDR: rd_word = {24'h000000, flags_ff};
         CFE_BRSTAT_ADDR: rd_word = {27'h0000000, brstat_ff};
         CFE_RESULT_ADDR: rd_word = {24'h000000, result_ff};
         default: rd_known = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= CFE_RESP_OKAY;
      end else if (s_axil_arvalid_i && arready_ff) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_word;
         rresp_ff <= rd_known ? CFE_RESP_OKAY : CFE_RESP_DECERR;
      end else if (rvalid_ff && s_axil_rready_i) begin
         rvalid_ff <= 1'b0;
         arready_ff <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign s_axil_awready_o = awready_ff;
   assign s_axil_wready_o = wready_ff;
   assign s_axil_bvalid_o = bvalid_ff;
   assign s_axil_bresp_o = bresp_ff;
   assign s_axil_arready_o = arready_ff;
   assign s_axil_rvalid_o = rvalid_ff;
   assign s_axil_rdata_o = rdata_ff;
   assign s_axil_rresp_o = rresp_ff;
   assign alu_result_o = result_ff;
   assign alu_result_valid_o = result_valid_ff;
   assign flags_o = flags_ff;
   assign br_done_o = br_done_ff;
   assign br_taken_o = br_taken_ff;
   assign br_pc_o = br_pc_ff;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   logic [8:0] exp_add;
   logic [4:0] exp_add_low;
   logic exp_ovf;
   logic plain_add;
   logic any_wr;
   logic [7:0] exp_tests;
   logic exp_take;

   assign exp_add = {1'b0, alu_a_i} + {1'b0, alu_b_i};
   assign exp_add_low = {1'b0, alu_a_i[3:0]} + {1'b0, alu_b_i[3:0]};
   assign exp_ovf = (alu_a_i[7] == alu_b_i[7]) && (exp_add[7] != alu_a_i[7]);
   assign any_wr = core_flag_wr || axi_flag_wr;
   assign plain_add = alu_valid_i && (alu_op_i == CFE_OP_ADD) && !any_wr;
   // Written apart from the shared decoder so a slip in it shows up here
   assign exp_tests = {flags_ff[CFE_C_BIT], flags_ff[CFE_Z_BIT], flags_ff[CFE_S_BIT], flags_ff[CFE_V_BIT],
                       flags_ff[CFE_C_BIT] | flags_ff[CFE_Z_BIT],
                       flags_ff[CFE_Z_BIT] | (flags_ff[CFE_S_BIT] ^ flags_ff[CFE_V_BIT]),
                       flags_ff[CFE_S_BIT] ^ flags_ff[CFE_V_BIT], 1'b0};
   assign exp_take = exp_tests[branch_test_field_i[2:0]] ^ branch_test_field_i[3];

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_core_write_wins: assert property (core_flag_wr |=> flags_ff == $past(core_wdata_i))
      else $error("core flag write lost");
   chk_user_bits_hold: assert property (!any_wr |=> flags_ff[1:0] == $past(flags_ff[1:0]))
      else $error("user bits changed without write");
   chk_add_carry: assert property (plain_add |=> flags_ff[CFE_C_BIT] == $past(exp_add[8]))
      else $error("add carry wrong");
   chk_add_half_carry: assert property (plain_add |=> flags_ff[CFE_H_BIT] == $past(exp_add_low[4]))
      else $error("add half carry wrong");
   chk_add_overflow: assert property (plain_add |=> flags_ff[CFE_V_BIT] == $past(exp_ovf))
      else $error("add overflow wrong");
   chk_zero_sign: assert property (alu_valid_i && alu_wr_res && !any_wr |=>
      alu_result_valid_o && flags_ff[CFE_Z_BIT] == (alu_result_o == 8'h00) &&
      flags_ff[CFE_S_BIT] == alu_result_o[7])
      else $error("zero or sign flag disagrees with result");
   chk_decimal_mode: assert property (alu_valid_i && alu_op_i == CFE_OP_SUB && !any_wr |=>
      flags_ff[CFE_D_BIT])
      else $error("decimal flag not set by subtract");
   chk_rotate_carry: assert property (alu_valid_i && alu_op_i == CFE_OP_RLC && !any_wr |=>
      flags_ff[CFE_C_BIT] == $past(alu_a_i[7]) && alu_result_o[0] == $past(flags_ff[CFE_C_BIT]))
      else $error("rotate through carry wrong");
   chk_branch_test: assert property (br_req_i |=> br_done_o &&
      br_taken_o == $past(exp_take))
      else $error("branch decision wrong");
   chk_fixed_codes: assert property (br_req_i && (branch_test_field_i == CFE_CC_NEVER ||
      branch_test_field_i == CFE_CC_ALWAYS) |=> br_taken_o == $past(branch_test_field_i[3]))
      else $error("fixed condition code wrong");
   chk_branch_fallthru: assert property (br_req_i ##1 !br_taken_o |-> br_pc_o == $past(br_pc_next_i))
      else $error("untaken branch moved pc");

   cov_axi_flag_write: cover property (axi_flag_wr ##1 s_axil_bvalid_o);
   cov_branch_taken: cover property (br_req_i ##1 br_taken_o);
   cov_branch_skipped: cover property (br_req_i ##1 !br_taken_o);
   cov_write_over_alu: cover property (alu_valid_i && core_flag_wr);
endmodule

// ### inc/cfe_cond_if.sv
`timescale 1ns/1ps
interface cfe_cond_if;
   logic [7:0] flags;
   logic [3:0] code;
   logic rel;
   logic [15:0] target;
   logic [7:0] offset;
   logic [15:0] pc_next;
   logic taken;
   logic [15:0] pc_dest;
   modport eval (input flags, code, rel, target, offset, pc_next, output taken, pc_dest);
   modport user (output flags, code, rel, target, offset, pc_next, input taken, pc_dest);
endinterface

// ### inc/cfe_pkg.sv
package cfe_pkg;

   // ----------------------------------------------------------------
   // Register map and field layout
   // ----------------------------------------------------------------
   localparam int CFE_ADDR_W = 12;
   localparam logic [11:0] CFE_FLAGS_LIN_ADDR = 12'h0FC;
   localparam logic [7:0] CFE_FLAGS_SHORT_ADDR = 8'hFC;
   localparam logic [11:0] CFE_BRSTAT_ADDR = 12'h0F8;
   localparam logic [11:0] CFE_RESULT_ADDR = 12'h0F4;
   localparam logic [7:0] CFE_FLAGS_RST = 8'h00;
   localparam int CFE_C_BIT = 7;
   localparam int CFE_Z_BIT = 6;
   localparam int CFE_S_BIT = 5;
   localparam int CFE_V_BIT = 4;
   localparam int CFE_D_BIT = 3;
   localparam int CFE_H_BIT = 2;
   localparam int CFE_U1_BIT = 1;
   localparam int CFE_U2_BIT = 0;
   localparam logic [1:0] CFE_RESP_OKAY = 2'h0;
   localparam logic [1:0] CFE_RESP_DECERR = 2'h3;

   // ----------------------------------------------------------------
   // Decimal adjust constants and condition codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CFE_DA_LO = 8'h06;
   localparam logic [7:0] CFE_DA_HI = 8'h60;
   localparam logic [7:0] CFE_DA_MAX = 8'h99;
   localparam logic [3:0] CFE_DA_NIB = 4'h9;
   localparam logic [3:0] CFE_CC_NEVER = 4'h0;
   localparam logic [3:0] CFE_CC_ALWAYS = 4'h8;

   typedef enum logic [4:0] {
      CFE_OP_ADD, CFE_OP_ADC, CFE_OP_SUB, CFE_OP_SBC, CFE_OP_CP,
      CFE_OP_AND, CFE_OP_OR, CFE_OP_XOR, CFE_OP_COM,
      CFE_OP_INC, CFE_OP_DEC,
      CFE_OP_RL, CFE_OP_RLC, CFE_OP_RR, CFE_OP_RRC, CFE_OP_SRA, CFE_OP_SRL,
      CFE_OP_DA, CFE_OP_CCF, CFE_OP_RCF, CFE_OP_SCF
   } cfe_op_type;

   // ----------------------------------------------------------------
   // Shared decoders
   // ----------------------------------------------------------------
   // Low three bits pick the test, top bit inverts it
   function automatic logic cfe_test(input logic [3:0] code, input logic [7:0] f);
      logic c;
      logic z;
      logic s;
      logic v;
      logic r;
      c = f[CFE_C_BIT];
      z = f[CFE_Z_BIT];
      s = f[CFE_S_BIT];
      v = f[CFE_V_BIT];
      case (code[2:0])
         3'h0: r = 1'b0;
         3'h1: r = s ^ v;
         3'h2: r = z | (s ^ v);
         3'h3: r = c | z;
         3'h4: r = v;
         3'h5: r = s;
         3'h6: r = z;
         3'h7: r = c;
         default: r = 1'b0;
      endcase
      return r ^ code[3];
   endfunction

   function automatic logic cfe_hits_flags(input logic [11:0] addr, input logic short_mode);
      return short_mode ? (addr[7:0] == CFE_FLAGS_SHORT_ADDR) : (addr == CFE_FLAGS_LIN_ADDR);
   endfunction

endpackage

// ### verification/cfe_top_test.sv
`timescale 1ns/1ps
module cfe_top_test;
   import cfe_pkg::*;
   // ------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000, core_addr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata;
   logic awready, wready, bvalid, arready, rvalid, res_valid, br_done, br_taken;
   logic [1:0] bresp, rresp, resp;
   logic alu_valid = 1'b0, core_wr = 1'b0, core_short = 1'b0, br_req = 1'b0, br_rel = 1'b0;
   cfe_op_type alu_op = CFE_OP_ADD;
   logic [7:0] alu_a = 8'h00, alu_b = 8'h00, core_wdata = 8'h00, br_off = 8'h00, res, flags;
   logic [3:0] br_code = 4'h0;
   logic [15:0] br_pc;
   int n_mismatch = 0, n_compared = 0;

   always #2.5 clk = ~clk;

   cfe_top dut (.clk_i(clk), .rst_i(rst),
      .s_axil_awvalid_i(awvalid), .s_axil_awready_o(awready), .s_axil_awaddr_i(awaddr),
      .s_axil_wvalid_i(wvalid), .s_axil_wready_o(wready), .s_axil_wdata_i(wdata), .s_axil_wstrb_i(4'hF),
      .s_axil_bvalid_o(bvalid), .s_axil_bready_i(bready), .s_axil_bresp_o(bresp),
      .s_axil_arvalid_i(arvalid), .s_axil_arready_o(arready), .s_axil_araddr_i(araddr),
      .s_axil_rvalid_o(rvalid), .s_axil_rready_i(rready), .s_axil_rdata_o(rdata), .s_axil_rresp_o(rresp),
      .alu_valid_i(alu_valid), .alu_op_i(alu_op), .alu_a_i(alu_a), .alu_b_i(alu_b),
      .alu_result_o(res), .alu_result_valid_o(res_valid),
      .core_wr_i(core_wr), .core_short_i(core_short), .core_addr_i(core_addr), .core_wdata_i(core_wdata),
      .flags_o(flags), .br_req_i(br_req), .br_rel_i(br_rel), .branch_test_field_i(br_code),
      .br_target_i(16'h1234), .br_offset_i(br_off), .br_pc_next_i(16'h0200),
      .br_done_o(br_done), .br_taken_o(br_taken), .br_pc_o(br_pc));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Each channel released at its own handshake edge
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   // Core write and operation may share one edge
   task automatic step(input logic wr, input logic sh, input logic [11:0] ad, input logic [7:0] wd,
                       input logic op_on, input cfe_op_type op, input logic [7:0] a, input logic [7:0] b);
      @(posedge clk);
      core_wr <= wr;
      core_short <= sh;
      core_addr <= ad;
      core_wdata <= wd;
      alu_valid <= op_on;
      alu_op <= op;
      alu_a <= a;
      alu_b <= b;
      @(posedge clk);
      core_wr <= 1'b0;
      alu_valid <= 1'b0;
      #1;
   endtask

   task automatic br_go(input logic [3:0] k, input logic rel, input logic [7:0] off);
      @(posedge clk);
      br_req <= 1'b1;
      br_code <= k;
      br_rel <= rel;
      br_off <= off;
      @(posedge clk);
      br_req <= 1'b0;
      #1;
   endtask

   function automatic logic exp_cc(input logic [3:0] k, input logic [7:0] f);
      logic c, z, s, v;
      {c, z, s, v} = f[7:4];
      case (k)
         4'h0: return 1'b0;
         4'h1: return s ^ v;
         4'h2: return z | (s ^ v);
         4'h3: return c | z;
         4'h4: return v;
         4'h5: return s;
         4'h6: return z;
         4'h7: return c;
         4'h8: return 1'b1;
         4'h9: return !(s ^ v);
         4'hA: return !(z | (s ^ v));
         4'hB: return !c && !z;
         4'hC: return !v;
         4'hD: return !s;
         4'hE: return !z;
         default: return !c;
      endcase
   endfunction

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      logic [31:0] d;
      axi_wr(12'h0FC, 32'hFFFF_FF03);
      chk("wr resp", {30'h0, resp}, {30'h0, CFE_RESP_OKAY});
      axi_rd(12'h0FC, d);
      chk("flags rd", d, 32'h0000_0003);
      axi_rd(12'h100, d);
      chk("unmapped resp", {30'h0, resp}, {30'h0, CFE_RESP_DECERR});
   endtask

   task automatic t_arith();
      step(1'b0, 1'b0, 12'h000, 8'h00, 1'b1, CFE_OP_ADD, 8'h8F, 8'h81);
      chk("add", {15'h0, res_valid, res, flags}, {15'h0, 1'b1, 8'h10, 8'h97});
      step(1'b0, 1'b0, 12'h000, 8'h00, 1'b1, CFE_OP_SUB, 8'h00, 8'h01);
      chk("sub borrow", {16'h0, res, flags}, {16'h0, 8'hFF, 8'hAF});
      step(1'b0, 1'b0, 12'h000, 8'h00, 1'b1, CFE_OP_SUB, 8'h05, 8'h05);
      chk("sub zero", {16'h0, res, flags}, {16'h0, 8'h00, 8'h4B});
      step(1'b0, 1'b0, 12'h000, 8'h00, 1'b1, CFE_OP_AND, 8'hF0, 8'h80);
      chk("and sign", {18'h0, res, flags[7:4], flags[1:0]}, {18'h0, 8'h80, 4'h2, 2'h3});
      step(1'b0, 1'b0, 12'h000, 8'h00, 1'b1, CFE_OP_RRC, 8'h01, 8'h00);
      chk("rrc carry", {23'h0, res, flags[7]}, {23'h0, 8'h00, 1'b1});
      // Carry left set above must enter the sum
      step(1'b0, 1'b0, 12'h000, 8'h00, 1'b1, CFE_OP_ADC, 8'hFF, 8'h00);
      chk("adc carry in", {16'h0, res, flags}, {16'h0, 8'h00, 8'hC7});
      step(1'b0, 1'b0, 12'h000, 8'h00, 1'b1, CFE_OP_RLC, 8'h40, 8'h00);
      chk("rlc through", {16'h0, res, flags}, {16'h0, 8'h81, 8'h37});
      step(1'b0, 1'b0, 12'h000, 8'h00, 1'b1, CFE_OP_ADD, 8'h15, 8'h27);
      step(1'b0, 1'b0, 12'h000, 8'h00, 1'b1, CFE_OP_DA, 8'h3C, 8'h00);
      chk("decimal adjust", {16'h0, res, flags}, {16'h0, 8'h42, 8'h03});
   endtask

   task automatic t_prio();
      step(1'b1, 1'b1, 12'hAFC, 8'h22, 1'b1, CFE_OP_ADD, 8'h00, 8'h00);
      chk("write beats op", {24'h0, flags}, 32'h22);
      step(1'b1, 1'b0, 12'hAFC, 8'h55, 1'b0, CFE_OP_ADD, 8'h00, 8'h00);
      chk("linear miss", {24'h0, flags}, 32'h22);
   endtask

   task automatic t_cond();
      logic [7:0] pats [4] = '{8'h00, 8'hF0, 8'h50, 8'hA0};
      logic e;
      for (int p = 0; p < 4; p++) begin
         step(1'b1, 1'b0, 12'h0FC, pats[p], 1'b0, CFE_OP_ADD, 8'h00, 8'h00);
         for (int k = 0; k < 16; k++) begin
            e = exp_cc(4'(k), pats[p]);
            br_go(4'(k), 1'b0, 8'h00);
            chk("branch", {14'h0, br_done, br_taken, br_pc}, {14'h0, 1'b1, e, e ? 16'h1234 : 16'h0200});
         end
      end
      br_go(4'h8, 1'b1, 8'hF0);
      chk("relative", {16'h0, br_pc}, 32'h01F0);
   endtask

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_arith();
      t_prio();
      t_cond();
      close_out();
   end

   // Watchdog well beyond the fewer than two hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      close_out();
   end
endmodule
